// File: hw/ubrd_baud_divider.v
// baud rate divider top: axi4-lite registers plus prescaler
// assumes one master, one write and one read outstanding at a time
`include "ubrd_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module ubrd_baud_divider (
  input  wire        clock,         // 250 MHz system clock
  input  wire        sys_rst,       // synchronous reset, active high
  input  wire [3:0]  s_axi_awaddr,  // write address
  input  wire        s_axi_awvalid, // write address valid
  output reg         s_axi_awready, // write address ready
  input  wire [31:0] s_axi_wdata,   // write data
  input  wire [3:0]  s_axi_wstrb,   // write byte strobes
  input  wire        s_axi_wvalid,  // write data valid
  output reg         s_axi_wready,  // write data ready
  output reg  [1:0]  s_axi_bresp,   // write response
  output reg         s_axi_bvalid,  // write response valid
  input  wire        s_axi_bready,  // write response ready
  input  wire [3:0]  s_axi_araddr,  // read address
  input  wire        s_axi_arvalid, // read address valid
  output reg         s_axi_arready, // read address ready
  output reg  [31:0] s_axi_rdata,   // read data
  output reg  [1:0]  s_axi_rresp,   // read response
  output reg         s_axi_rvalid,  // read data valid
  input  wire        s_axi_rready,  // read data ready
  output reg         baudTick,      // oversample tick to tx/rx
  output reg         bitTick,       // bit-time enable to tx/rx
  output reg         doubleSpeed    // double_speed_select to tx/rx
);
  reg [3:0]  divHigh;
  reg [7:0]  divLow;
  reg        legacyMode;
  reg [3:0]  awAddr;
  reg        awHeld;
  reg [31:0] wData;
  reg        wLane0;
  reg        wHeld;
  reg        reload;
  wire       tickRaw;
  wire       bitRaw;
  wire [11:0] divisor;
  // write decode results, settled before the response edge
  reg        wrFire;           // both halves held, no response yet
  reg        wrOk;             // write address mapped in this mode
  reg [3:0]  next_divHigh;     // high nibble after this cycle
  reg [7:0]  next_divLow;      // low byte after this cycle
  reg        next_doubleSpeed; // speed select after this cycle
  reg        next_legacyMode;  // legacy mode after this cycle
  reg        next_reload;      // prescaler reload request
  // read select results, taken with the read address
  reg        rdOk;             // read address mapped in this mode
  reg [31:0] next_rdata;       // word for the offered read address

  // address known and present in the current mode
  function mapped;
    input [3:0] a;
    input       legacy;
    begin
      mapped = (a == `UBRD_OFS_LOW) || (a == `UBRD_OFS_CTRL) ||
               (a == `UBRD_OFS_STATUS) ||
               ((a == `UBRD_OFS_HIGH) && !legacy);
    end
  endfunction

  // legacy mode drops the high nibble
  assign divisor = legacyMode ? {4'h0, divLow} : {divHigh, divLow};

  // register write decode; settings move on the edge that raises bvalid,
  // so a read issued after the response always sees the new value
  always @* begin
    wrFire           = awHeld && wHeld && !s_axi_bvalid;
    wrOk             = mapped(awAddr, legacyMode);
    next_divHigh     = divHigh;
    next_divLow      = divLow;
    next_doubleSpeed = doubleSpeed;
    next_legacyMode  = legacyMode;
    next_reload      = 1'b0;
    if (wrFire && wrOk && wLane0) begin
      case (awAddr)
        // upper bits discarded, read as zero
        `UBRD_OFS_HIGH: begin
          next_divHigh = wData[`UBRD_HIGH_MSB:0];
        end
        `UBRD_OFS_LOW: begin
          next_divLow = wData[`UBRD_LOW_MSB:0];
          next_reload = 1'b1;
        end
        `UBRD_OFS_CTRL: begin
          next_doubleSpeed = wData[`UBRD_CTRL_DSPEED];
          next_legacyMode  = wData[`UBRD_CTRL_LEGACY];
        end
        default: begin
          next_reload = 1'b0;
        end
      endcase
    end
  end

  // write channels taken in either order, answered when both held
  always @(posedge clock) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `UBRD_RESP_OKAY;
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= 4'h0;
      wData         <= 32'h0000_0000;
      wLane0        <= 1'b0;
      divHigh       <= 4'h0;
      divLow        <= 8'h00;
      legacyMode    <= 1'b0;
      doubleSpeed   <= 1'b0;
      reload        <= 1'b0;
    end else begin
      divHigh     <= next_divHigh;
      divLow      <= next_divLow;
      doubleSpeed <= next_doubleSpeed;
      legacyMode  <= next_legacyMode;
      reload      <= next_reload;
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr        <= s_axi_awaddr;
        awHeld        <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData        <= s_axi_wdata;
        wLane0       <= s_axi_wstrb[0];
        wHeld        <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      // unmapped or absent register: error response, nothing written
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrOk ? `UBRD_RESP_OKAY : `UBRD_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        awHeld        <= 1'b0;
        wHeld         <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read word select; the status word shows what the prescaler uses,
  // which differs from the two bytes while legacy mode is on
  always @* begin
    rdOk = mapped(s_axi_araddr, legacyMode);
    case (s_axi_araddr)
      `UBRD_OFS_HIGH: begin
        next_rdata = legacyMode ? 32'h0000_0000 : {28'h0, divHigh};
      end
      `UBRD_OFS_LOW: begin
        next_rdata = {24'h0, divLow};
      end
      `UBRD_OFS_CTRL: begin
        next_rdata = {30'h0, legacyMode, doubleSpeed};
      end
      // effective divisor as the prescaler sees it
      `UBRD_OFS_STATUS: begin
        next_rdata = {20'h0, divisor};
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // read channel: answer one cycle after address taken
  always @(posedge clock) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `UBRD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= rdOk ? `UBRD_RESP_OKAY : `UBRD_RESP_SLVERR;
      s_axi_rdata   <= next_rdata;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // no guard on live frames; software must wait for idle
  ubrd_prescaler prescaler (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .divisor     (divisor),
    .doubleSpeed (doubleSpeed),
    .reload      (reload),
    .baudTick    (tickRaw),
    .bitTick     (bitRaw)
  );

  // outputs registered once more so they leave from flip-flops here;
  // costs one clock of latency, the same for both ticks
  always @(posedge clock) begin
    if (sys_rst) begin
      baudTick <= 1'b0;
      bitTick  <= 1'b0;
    end else begin
      baudTick <= tickRaw;
      bitTick  <= bitRaw;
    end
  end
endmodule
`default_nettype wire

// File: hw/ubrd_defines.vh
// constants for the baud rate divider: register map, fields, reset values
// assumes a 32-bit axi4-lite slave with one register per aligned word
`ifndef UBRD_DEFINES_VH
`define UBRD_DEFINES_VH
`define UBRD_OFS_HIGH     4'h0
`define UBRD_OFS_LOW      4'h4
`define UBRD_OFS_CTRL     4'h8
`define UBRD_OFS_STATUS   4'hC
`define UBRD_DIV_W        12
`define UBRD_DIV_RST      12'h000
`define UBRD_HIGH_MSB     3
`define UBRD_LOW_MSB      7
`define UBRD_CTRL_DSPEED  0
`define UBRD_CTRL_LEGACY  1
`define UBRD_TICKS_NORMAL 4'hF
`define UBRD_TICKS_DOUBLE 4'h7
`define UBRD_RESP_OKAY    2'h0
`define UBRD_RESP_SLVERR  2'h2
`endif

// File: hw/ubrd_prescaler.v
// baud prescaler: tick every divisor+1 clocks, bit enable every 16 or 8 ticks
// assumes reload is a one-cycle pulse in the system clock domain
`include "ubrd_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module ubrd_prescaler (
  input  wire        clock,       // system clock
  input  wire        sys_rst,     // synchronous reset, active high
  input  wire [11:0] divisor,     // effective divisor
  input  wire        doubleSpeed, // double_speed_select
  input  wire        reload,      // immediate reload pulse
  output reg         baudTick,    // oversample tick pulse
  output reg         bitTick      // one pulse per bit time
);
  reg [11:0] count;
  reg [3:0]  tickCount;
  // reload restarts the period without waiting for its end
  always @(posedge clock) begin
    if (sys_rst) begin
      count    <= `UBRD_DIV_RST;
      baudTick <= 1'b0;
    end else if (reload) begin
      count    <= divisor;
      baudTick <= 1'b0;
    end else if (count == 12'h000) begin
      count    <= divisor;
      baudTick <= 1'b1;
    end else begin
      count    <= count - 12'h001;
      baudTick <= 1'b0;
    end
  end
  // sixteen or eight ticks per bit
  // divisor zero: bit every 16 or 8 clocks
  always @(posedge clock) begin
    if (sys_rst || reload) begin
      tickCount <= 4'h0;
      bitTick   <= 1'b0;
    end else if (count == 12'h000) begin
      if (tickCount >= (doubleSpeed ? `UBRD_TICKS_DOUBLE
                                    : `UBRD_TICKS_NORMAL)) begin
        tickCount <= 4'h0;
        bitTick   <= 1'b1;
      end else begin
        tickCount <= tickCount + 4'h1;
        bitTick   <= 1'b0;
      end
    end else begin
      bitTick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: verification/tb_ubrd_baud_divider.sv
// bench: registers, reload and tick timing of the baud divider
// assumes design, checker and tick model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_ubrd_baud_divider;
  logic clock = 0, sys_rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, baudTick, bitTick, doubleSpeed;
  int errors = 0, num_checks = 0, period, perBit, n, d, h;
  logic [33:0] wq[$], rq[$];
  ubrd_baud_divider dut (.*);
  ubrd_txrx_model tick (.*);
  always #2 clock = ~clock;
  task automatic chk(string nm, logic [33:0] s, logic [33:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // bound on every handshake wait
  task automatic guard;
    if (++n > 30) begin
      errors++;
      end_of_test();
    end
  endtask
  // write: aw and w together, bready raised once bvalid seen
  task automatic wr(logic [3:0] a, logic [31:0] v, logic [1:0] r);
    logic done;
    wq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    n = 0;
    do begin
      @(posedge clock);
      done = s_axi_bvalid && s_axi_bready;
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      s_axi_bready <= s_axi_bvalid && !done;
      guard();
    end while (!done);
  endtask
  // read: late rready so the data must stand a cycle
  task automatic rd(logic [3:0] a, logic [33:0] e);
    logic done;
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    n = 0;
    do begin
      @(posedge clock);
      done = s_axi_rvalid && s_axi_rready;
      if (s_axi_arready) s_axi_arvalid <= 0;
      s_axi_rready <= s_axi_rvalid && !done;
      guard();
    end while (!done);
  endtask
  // monitor: oldest note against each response
  always @(posedge clock) begin
    if (s_axi_bvalid && s_axi_bready)
      chk("bresp", s_axi_bresp, wq.pop_front());
    if (s_axi_rvalid && s_axi_rready)
      chk("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
  end
  initial begin
    void'($urandom(47));
    repeat (6) @(posedge clock);
    sys_rst <= 0;
    @(posedge clock);
    h = $urandom % 16;
    d = $urandom % 8;
    for (int i = 0; i < 16; i += 4) rd(4'(i), 0);
    wr(4'h0, h, 0);
    wr(4'h4, 32'hC8, 0);
    rd(4'h0, h);
    rd(4'hC, {h[3:0], 8'hC8});
    $display("test registers done");
    wr(4'h0, 0, 0);
    wr(4'h4, d, 0);
    for (n = 0; n < d + 8 && !baudTick; n++) @(posedge clock);
    chk("reload", baudTick, 1);
    repeat (40 * d + 40) @(posedge clock);
    chk("period", period, d + 1);
    chk("perBit", perBit, 16);
    $display("test reload done");
    wr(4'h8, 1, 0);
    wr(4'h4, 0, 0);
    repeat (40) @(posedge clock);
    chk("double", {doubleSpeed, 8'(period), 8'(perBit)}, 17'h10108);
    $display("test double speed done");
    wr(4'h0, 3, 0);
    wr(4'h8, 2, 0);
    wr(4'h0, 5, 2);
    // lane 0 off: the low byte must not move
    s_axi_wstrb <= 4'h0;
    wr(4'h4, 32'hFF, 0);
    s_axi_wstrb <= 4'hF;
    rd(4'h0, 34'h200000000);
    rd(4'h8, 2);
    rd(4'hC, 0);
    // reload in legacy mode: held high nibble must not reach the ticks
    wr(4'h4, 0, 0);
    repeat (48) @(posedge clock);
    chk("legacy", {doubleSpeed, 8'(period), 8'(perBit)}, 17'h00110);
    $display("test legacy done");
    end_of_test();
  end
endmodule
bind ubrd_baud_divider ubrd_chk chk_i (.*);
`default_nettype wire

// File: verification/ubrd_chk.sv
// checker: bus handshake and tick relations of the baud divider
// assumes binding into ubrd_baud_divider, one clock domain
`timescale 1ns/1ps
`default_nettype none
module ubrd_chk (
  input wire logic clock,         // system clock
  input wire logic sys_rst,       // sync reset
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid,  // w valid
  input wire logic s_axi_wready,  // w ready
  input wire logic s_axi_bvalid,  // b valid
  input wire logic s_axi_bready,  // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid,  // r valid
  input wire logic s_axi_rready,  // r ready
  input wire logic baudTick,      // tick
  input wire logic bitTick,       // bit enable
  input wire logic doubleSpeed    // speed select
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // taken edges of a write and a read
  sequence wrTake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rdTake;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_BIT_ON_BAUD: assert property (bitTick |-> baudTick)
    else $error("bit tick without baud tick");
  AST_WR_ANSWER: assert property (wrTake |-> ##2 s_axi_bvalid)
    else $error("no write response after take");
  AST_RD_ANSWER: assert property (rdTake |=> s_axi_rvalid)
    else $error("no read data after take");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped early");
  AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  // speed select moves only with a write response
  AST_DS_WRITE: assert property ($changed(doubleSpeed) |-> s_axi_bvalid)
    else $error("speed select changed without a write");
endmodule
`default_nettype wire

// File: verification/ubrd_txrx_model.sv
// tick model: measures baud tick spacing and ticks per bit
// assumes ticks are one-cycle pulses on the system clock
`timescale 1ns/1ps
`default_nettype none
module ubrd_txrx_model (
  input wire logic clock,    // system clock
  input wire logic sys_rst,  // sync reset
  input wire logic baudTick, // oversample tick
  input wire logic bitTick,  // bit enable
  output var int   period,   // clocks between ticks
  output var int   perBit    // ticks per bit
);
  int gap, cnt;
  always @(posedge clock) begin
    if (sys_rst) begin
      gap <= 0;
      cnt <= 0;
    end else begin
      gap <= baudTick ? 1 : gap + 1;
      if (baudTick) period <= gap;
      if (bitTick) perBit <= cnt + 1;
      if (bitTick) cnt <= 0;
      else if (baudTick) cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire
